// *** rtl/isr_params.svh ***
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH

// seven-bit device address on the bus
`define ISR_SLAVE_ADDR 7'h20
// first register index of the reserved range (up to 8'hFF)
`define ISR_RSV_REG_LO 8'h20
// system clock period
`define ISR_CLK_PERIOD_NS 20
// least SCL low time of a fast-mode bus
`define ISR_T_LOW_NS 1300
// one quarter of an SCL bit: half the low time, rounded up to whole cycles
`define ISR_PHASE_CYC ((`ISR_T_LOW_NS / 2 + `ISR_CLK_PERIOD_NS - 1) / `ISR_CLK_PERIOD_NS)

`endif

// *** rtl/isr_pkg.sv ***
package isr_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_CMD,
    S_WDATA,
    S_ACK,
    S_TX,
    S_MACK
  } isr_slv_state_t;

  typedef enum logic [1:0] {
    M_IDLE,
    M_START,
    M_BYTE,
    M_STOP
  } isr_mst_state_t;

  typedef enum logic [2:0] {
    K_ADDRW,
    K_CMD,
    K_WDATA,
    K_ADDRR,
    K_RDATA
  } isr_kind_t;

  // a pin level counts once the second and third synchroniser stages agree
  function automatic logic isr_filt(input logic [2:0] sy, input logic cur);
    return (sy[2] == sy[1]) ? sy[2] : cur;
  endfunction : isr_filt

endpackage : isr_pkg

// *** rtl/isr_bus_if.sv ***
`timescale 1ns/1ps
interface isr_bus_if;
  logic m_scl_oe;
  logic m_sda_oe;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // open-drain lines with pull-ups: low whenever any end drives
  assign scl = ~m_scl_oe;
  assign sda = ~(m_sda_oe | s_sda_oe);

  modport master (
    output m_scl_oe,
    output m_sda_oe,
    input scl,
    input sda
  );

  modport slave (
    output s_sda_oe,
    input scl,
    input sda
  );
endinterface : isr_bus_if

// *** rtl/isr_slave.sv ***
`timescale 1ns/1ps
`include "isr_params.svh"
// Contract
// - master addresses device first with write bit
// - byte after address loads register pointer
// - master repeats start, address with read bit
// - read phase sends register at pointer
// - auto flag set: pointer steps on ack
// - auto flag clear: pointer stays, same register
// - next byte loaded at ack rising edge
// - reads of any length are accepted
// - master nacks last byte; device releases SDA
// - master never writes reserved registers (checks only the first register of a write; a burst can run into them)
// - auto flag set: pointer steps per write
// - master starts only on idle bus
module isr_slave
  import isr_pkg::*;
(
  // system
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  // two-wire bus
  isr_bus_if.slave BUS,
  // register file side
  input wire logic I_AUTO_INC,
  input wire logic [7:0] I_REG_RDATA,
  output logic [7:0] O_REG_ADDR,
  output logic O_WR_STB,
  output logic [7:0] O_WR_ADDR,
  output logic [7:0] O_WR_DATA,
  // status
  output logic O_BUSY
);

  logic [2:0] scl_sy_q;
  logic [2:0] sda_sy_q;
  logic scl_f_q;
  logic sda_f_q;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic receiving;
  logic addr_hit;
  logic ack_now;
  isr_slv_state_t state_q;
  isr_slv_state_t ack_next_q;
  logic [2:0] bit_q;
  logic rx_done_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic [7:0] rd_addr_q;
  logic mack_q;
  logic sda_oe_q;
  logic wr_stb_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;

  // pins come from outside the clock domain
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      scl_sy_q <= 3'h7;
      sda_sy_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_sy_q <= {scl_sy_q[1:0], BUS.scl};
      sda_sy_q <= {sda_sy_q[1:0], BUS.sda};
      scl_f_q <= isr_filt(scl_sy_q, scl_f_q);
      sda_f_q <= isr_filt(sda_sy_q, sda_f_q);
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  assign scl_rise = scl_f_q & ~scl_p_q;
  assign scl_fall = ~scl_f_q & scl_p_q;
  assign bus_start = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  assign bus_stop = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
  assign receiving = (state_q == S_ADDR) || (state_q == S_CMD) || (state_q == S_WDATA);
  // the first byte is taken as ours on either direction bit; only the seven address bits are compared
  assign addr_hit = (sh_q[7:1] == `ISR_SLAVE_ADDR);
  assign ack_now = scl_fall && rx_done_q && receiving && ((state_q != S_ADDR) || addr_hit);

  // byte framing and phase sequencing
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      state_q <= S_IDLE;
      ack_next_q <= S_IDLE;
      bit_q <= 3'h0;
      rx_done_q <= 1'b0;
    end else if (bus_start) begin
      // a repeated start lands here too, so the read address follows the command
      state_q <= S_ADDR;
      bit_q <= 3'h0;
      rx_done_q <= 1'b0;
    end else if (bus_stop) begin
      state_q <= S_IDLE;
      rx_done_q <= 1'b0;
    end else begin
      case (state_q)
        S_ADDR, S_CMD, S_WDATA: begin
          if (scl_rise) begin
            bit_q <= bit_q + 3'h1;
            rx_done_q <= (bit_q == 3'h7);
          end else if (scl_fall && rx_done_q) begin
            rx_done_q <= 1'b0;
            if (state_q == S_ADDR) begin
              if (addr_hit) begin
                state_q <= S_ACK;
                ack_next_q <= sh_q[0] ? S_TX : S_CMD;
              end else begin
                state_q <= S_IDLE;
              end
            end else begin
              state_q <= S_ACK;
              ack_next_q <= S_WDATA;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            state_q <= ack_next_q;
            bit_q <= 3'h0;
          end
        end
        S_TX: begin
          if (scl_fall) begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              state_q <= S_MACK;
            end
          end
        end
        S_MACK: begin
          // no byte count is kept: the master alone decides where a read ends
          if (scl_fall) begin
            state_q <= mack_q ? S_TX : S_IDLE;
            bit_q <= 3'h0;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // receive shifter
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      sh_q <= 8'h00;
    end else if (scl_rise && receiving) begin
      sh_q <= {sh_q[6:0], sda_f_q};
    end
  end

  // register pointer survives start, stop and foreign addresses
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      ptr_q <= 8'h00;
    end else if (scl_fall && rx_done_q && (state_q == S_CMD)) begin
      ptr_q <= sh_q;
    end else if (scl_fall && rx_done_q && (state_q == S_WDATA) && I_AUTO_INC) begin
      ptr_q <= ptr_q + 8'h01;
    end else if (scl_rise && (state_q == S_MACK) && !sda_f_q && I_AUTO_INC) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // read port looks one step ahead during the master's ack, so the byte
  // loaded on that edge is already the next register
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      rd_addr_q <= 8'h00;
    end else if ((state_q == S_MACK) && I_AUTO_INC) begin
      rd_addr_q <= ptr_q + 8'h01;
    end else begin
      rd_addr_q <= ptr_q;
    end
  end

  // transmit shifter
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      tx_q <= 8'hFF;
      mack_q <= 1'b0;
    end else if (scl_rise && (state_q == S_ACK) && (ack_next_q == S_TX)) begin
      tx_q <= I_REG_RDATA;
    end else if (scl_rise && (state_q == S_MACK)) begin
      mack_q <= ~sda_f_q;
      if (!sda_f_q) begin
        tx_q <= I_REG_RDATA;
      end
    end else if (scl_fall && (state_q == S_TX)) begin
      tx_q <= {tx_q[6:0], 1'b1};
    end
  end

  // data line drive, changed only while SCL is low
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      sda_oe_q <= 1'b0;
    end else if (bus_start || bus_stop) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall) begin
      if (ack_now) begin
        sda_oe_q <= 1'b1;
      end else if (state_q == S_ACK) begin
        sda_oe_q <= (ack_next_q == S_TX) && !tx_q[7];
      end else if (state_q == S_TX) begin
        sda_oe_q <= (bit_q != 3'h7) && !tx_q[6];
      end else if (state_q == S_MACK) begin
        sda_oe_q <= mack_q && !tx_q[7];
      end else begin
        sda_oe_q <= 1'b0;
      end
    end
  end

  // write path hand-off
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      wr_stb_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= scl_fall && rx_done_q && (state_q == S_WDATA);
      if (scl_fall && rx_done_q && (state_q == S_WDATA)) begin
        wr_addr_q <= ptr_q;
        wr_data_q <= sh_q;
      end
    end
  end

  assign BUS.s_sda_oe = sda_oe_q;
  assign O_REG_ADDR = rd_addr_q;
  assign O_WR_STB = wr_stb_q;
  assign O_WR_ADDR = wr_addr_q;
  assign O_WR_DATA = wr_data_q;
  assign O_BUSY = (state_q != S_IDLE);

endmodule : isr_slave

// *** rtl/isr_master.sv ***
`timescale 1ns/1ps
`include "isr_params.svh"
module isr_master
  import isr_pkg::*;
(
  // system
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  // two-wire bus
  isr_bus_if.master BUS,
  // request
  input wire logic I_REQ_VALID,
  output logic O_REQ_READY,
  input wire logic I_REQ_RNW,
  input wire logic [7:0] I_REQ_REG,
  input wire logic [7:0] I_REQ_LEN,
  // write data
  input wire logic [7:0] I_WR_DATA,
  output logic O_WR_TAKE,
  // read data
  output logic O_RD_VALID,
  output logic [7:0] O_RD_DATA,
  // completion
  output logic O_DONE,
  output logic O_ERR
);

  logic [2:0] scl_sy_q;
  logic [2:0] sda_sy_q;
  logic scl_f_q;
  logic sda_f_q;
  isr_mst_state_t state_q;
  isr_kind_t kind_q;
  logic [5:0] tmr_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] cnt_q;
  logic [7:0] reg_q;
  logic rnw_q;
  logic tick;
  logic bus_idle;
  logic accept;
  logic tx_kind;
  logic scl_oe_q;
  logic sda_oe_q;
  logic sda_oe_d;
  logic take_q;
  logic rd_valid_q;
  logic [7:0] rd_data_q;
  logic done_q;
  logic err_q;

  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      scl_sy_q <= 3'h7;
      sda_sy_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_sy_q <= {scl_sy_q[1:0], BUS.scl};
      sda_sy_q <= {sda_sy_q[1:0], BUS.sda};
      scl_f_q <= isr_filt(scl_sy_q, scl_f_q);
      sda_f_q <= isr_filt(sda_sy_q, sda_f_q);
    end
  end

  assign tick = (tmr_q == 6'h00);
  assign bus_idle = scl_f_q && sda_f_q;
  assign O_REQ_READY = (state_q == M_IDLE) && bus_idle;
  assign accept = I_REQ_VALID && O_REQ_READY;
  assign tx_kind = (kind_q != K_RDATA);

  // quarter-bit timer
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      tmr_q <= 6'(`ISR_PHASE_CYC - 1);
    end else if ((state_q == M_IDLE) || tick) begin
      tmr_q <= 6'(`ISR_PHASE_CYC - 1);
    end else begin
      tmr_q <= tmr_q - 6'h01;
    end
  end

  // data bits move SDA only in the second low quarter; start and stop also move it in the second high quarter
  always_comb begin
    sda_oe_d = sda_oe_q;
    case (state_q)
      M_IDLE: sda_oe_d = 1'b0;
      M_START: begin
        if (ph_q == 2'h1) begin
          sda_oe_d = 1'b0;
        end else if (ph_q == 2'h3) begin
          sda_oe_d = 1'b1;
        end
      end
      M_STOP: begin
        if (ph_q == 2'h1) begin
          sda_oe_d = 1'b1;
        end else if (ph_q == 2'h3) begin
          sda_oe_d = 1'b0;
        end
      end
      default: begin
        if (ph_q == 2'h1) begin
          if (bit_q == 4'h8) begin
            sda_oe_d = !tx_kind && (cnt_q != 8'h01);
          end else begin
            sda_oe_d = tx_kind && !sh_q[7];
          end
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      scl_oe_q <= (state_q != M_IDLE) && !ph_q[1];
      sda_oe_q <= sda_oe_d;
    end
  end

  // transfer sequencer
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      state_q <= M_IDLE;
      kind_q <= K_ADDRW;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      cnt_q <= 8'h00;
      reg_q <= 8'h00;
      rnw_q <= 1'b0;
      take_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      take_q <= 1'b0;
      rd_valid_q <= 1'b0;
      done_q <= 1'b0;
      if (state_q == M_IDLE) begin
        if (accept && !I_REQ_RNW && (I_REQ_REG >= `ISR_RSV_REG_LO)) begin
          done_q <= 1'b1;
          err_q <= 1'b1;
        end else if (accept) begin
          state_q <= M_START;
          ph_q <= 2'h2;
          kind_q <= K_ADDRW;
          rnw_q <= I_REQ_RNW;
          reg_q <= I_REQ_REG;
          cnt_q <= I_REQ_LEN;
          err_q <= 1'b0;
        end
      end else if (tick) begin
        ph_q <= ph_q + 2'h1;
        if (ph_q == 2'h3) begin
          case (state_q)
            M_START: begin
              state_q <= M_BYTE;
              sh_q <= {`ISR_SLAVE_ADDR, kind_q == K_ADDRR};
              bit_q <= 4'h0;
            end
            M_STOP: begin
              state_q <= M_IDLE;
              done_q <= 1'b1;
            end
            default: begin
              if (bit_q != 4'h8) begin
                sh_q <= {sh_q[6:0], sda_f_q};
                bit_q <= bit_q + 4'h1;
                if (!tx_kind && (bit_q == 4'h7)) begin
                  rd_data_q <= {sh_q[6:0], sda_f_q};
                  rd_valid_q <= 1'b1;
                end
              end else begin
                bit_q <= 4'h0;
                if (tx_kind && sda_f_q) begin
                  state_q <= M_STOP;
                  err_q <= 1'b1;
                end else begin
                  case (kind_q)
                    K_ADDRW: begin
                      kind_q <= K_CMD;
                      sh_q <= reg_q;
                    end
                    K_CMD: begin
                      if (rnw_q) begin
                        state_q <= M_START;
                        kind_q <= K_ADDRR;
                      end else begin
                        kind_q <= K_WDATA;
                        sh_q <= I_WR_DATA;
                        take_q <= 1'b1;
                      end
                    end
                    K_ADDRR: kind_q <= K_RDATA;
                    default: begin
                      if (cnt_q == 8'h01) begin
                        state_q <= M_STOP;
                      end else begin
                        cnt_q <= cnt_q - 8'h01;
                        if (kind_q == K_WDATA) begin
                          sh_q <= I_WR_DATA;
                          take_q <= 1'b1;
                        end
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
      end
    end
  end

  assign BUS.m_scl_oe = scl_oe_q;
  assign BUS.m_sda_oe = sda_oe_q;
  assign O_WR_TAKE = take_q;
  assign O_RD_VALID = rd_valid_q;
  assign O_RD_DATA = rd_data_q;
  assign O_DONE = done_q;
  assign O_ERR = err_q;

endmodule : isr_master

// *** verif/isr_props.sv ***
`timescale 1ns/1ps
`include "isr_params.svh"
module isr_props (
  // system
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  // bus lines
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam logic [6:0] ADDR = `ISR_SLAVE_ADDR;
  logic scl_q, sda_q, rd_q, nack_q, idle_q, rise, start, stop;
  logic [3:0] bcnt_q;
  logic [7:0] nbyte_q, sh_q;

  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;

  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // bit and byte position since the last start; ninth bit is the acknowledge
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      bcnt_q <= 4'h0;
      nbyte_q <= 8'h00;
      sh_q <= 8'h00;
    end else if (start) begin
      bcnt_q <= 4'h0;
      nbyte_q <= 8'h00;
    end else if (rise && bcnt_q == 4'h8) begin
      bcnt_q <= 4'h0;
      // saturate so that long reads never look like an address byte
      if (nbyte_q != 8'hff) begin
        nbyte_q <= nbyte_q + 8'h01;
      end
    end else if (rise) begin
      bcnt_q <= bcnt_q + 4'h1;
      sh_q <= {sh_q[6:0], sda};
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      rd_q <= 1'b0;
      nack_q <= 1'b0;
      idle_q <= 1'b1;
    end else if (start) begin
      rd_q <= 1'b0;
      nack_q <= 1'b0;
      idle_q <= 1'b0;
    end else if (stop) begin
      idle_q <= 1'b1;
    end else if (rise && bcnt_q == 4'h8) begin
      if (nbyte_q == 8'h00) begin
        rd_q <= sh_q[0];
      end else if (rd_q && sda) begin
        nack_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RESET);

  sequence s_ninth;
    rise && bcnt_q == 4'h8;
  endsequence

  property p_addr_w_ack;
    s_ninth ##0 (nbyte_q == 8'h00 && sh_q == {ADDR, 1'b0}) |-> !sda;
  endproperty
  a_addr_w_ack: assert property (p_addr_w_ack) else $error("write address not acked");

  property p_cmd_ack;
    s_ninth ##0 (nbyte_q == 8'h01 && !rd_q) |-> !sda;
  endproperty
  a_cmd_ack: assert property (p_cmd_ack) else $error("command byte not acked");

  property p_addr_r_ack;
    s_ninth ##0 (nbyte_q == 8'h00 && sh_q == {ADDR, 1'b1}) |-> !sda;
  endproperty
  a_addr_r_ack: assert property (p_addr_r_ack) else $error("read address not acked");

  property p_rd_quiet;
    rise && rd_q && nbyte_q != 8'h00 && bcnt_q != 4'h8 && !nack_q |-> !m_sda_oe;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("master drives read data bit");

  property p_chg_low;
    $changed(s_sda_oe) |-> !scl && !scl_q;
  endproperty
  a_chg_low: assert property (p_chg_low) else $error("slave moved sda with scl high");

  property p_wr_ack;
    s_ninth ##0 (nbyte_q >= 8'h02 && !rd_q) |-> !sda;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write data not acked");

  property p_nack_rel;
    nack_q |-> !s_sda_oe;
  endproperty
  a_nack_rel: assert property (p_nack_rel) else $error("sda held after nack");

  property p_stop_rel;
    idle_q |-> !s_sda_oe;
  endproperty
  a_stop_rel: assert property (p_stop_rel) else $error("sda held after stop");
endmodule : isr_props

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`include "isr_params.svh"
module testbench;
  import isr_pkg::*;
  logic clk, rst, auto_inc, req_valid, req_rnw, scl_d, sda_d;
  logic req_ready, wr_take, rd_valid, done, err, wr_stb, busy;
  logic [7:0] req_reg, req_len, wr_data, rd_data, reg_addr, reg_rdata, wr_addr, wr_dat, sb;
  logic [7:0] mem [256];
  logic [7:0] mdl [256];
  logic [7:0] xrd [$], xwa [$], xwd [$], xfirst [$], wq [$];
  int n_fail, samples_checked, bc, nfall;

  isr_bus_if bus ();
  isr_slave isr_slave_inst (.I_CLK_SYS(clk), .I_RESET(rst), .BUS(bus), .I_AUTO_INC(auto_inc),
    .I_REG_RDATA(reg_rdata), .O_REG_ADDR(reg_addr), .O_WR_STB(wr_stb), .O_WR_ADDR(wr_addr),
    .O_WR_DATA(wr_dat), .O_BUSY(busy));
  isr_master isr_master_inst (.I_CLK_SYS(clk), .I_RESET(rst), .BUS(bus),
    .I_REQ_VALID(req_valid), .O_REQ_READY(req_ready), .I_REQ_RNW(req_rnw),
    .I_REQ_REG(req_reg), .I_REQ_LEN(req_len), .I_WR_DATA(wr_data), .O_WR_TAKE(wr_take),
    .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data), .O_DONE(done), .O_ERR(err));
  isr_props isr_props_inst (.I_CLK_SYS(clk), .I_RESET(rst), .m_scl_oe(bus.m_scl_oe),
    .m_sda_oe(bus.m_sda_oe), .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda));

  // register file beside the slave
  assign reg_rdata = mem[reg_addr];

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic run_req(input logic rnw, input logic [7:0] r, input logic [7:0] n,
                         input logic a);
    logic rsv;
    logic [7:0] d;
    int k;
    rsv = !rnw && (r >= `ISR_RSV_REG_LO);
    for (k = 0; k < n; k++) begin
      d = 8'($urandom);
      if (rnw) begin
        xrd.push_back(mdl[8'(r + k * a)]);
      end else if (!rsv) begin
        wq.push_back(d);
        xwa.push_back(8'(r + k * a));
        xwd.push_back(d);
        mdl[8'(r + k * a)] = d;
      end
    end
    if (!rsv) begin
      xfirst.push_back({`ISR_SLAVE_ADDR, 1'b0});
    end
    if (rnw) begin
      xfirst.push_back({`ISR_SLAVE_ADDR, 1'b1});
    end
    nfall = 0;
    @(negedge clk);
    auto_inc = a;
    k = 0;
    while (req_ready !== 1'b1 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    // a request only goes out onto a quiet bus; a run-out wait fails here
    cmp_bit(req_ready, 1'b1);
    cmp_bit(bus.scl & bus.sda, 1'b1);
    req_valid = 1'b1;
    req_rnw = rnw;
    req_reg = r;
    req_len = n;
    @(negedge clk);
    req_valid = 1'b0;
    k = 0;
    // looked at mid-cycle, where the one-cycle done pulse stands settled
    while (done !== 1'b1 && k < 40000) begin
      @(negedge clk);
      k++;
    end
    cmp_bit(done, 1'b1);
    cmp_bit(err, rsv);
    @(negedge clk);
    cmp_byte(8'(xrd.size() + xwa.size() + xfirst.size()), 8'h00);
    cmp_bit(busy, 1'b0);
    if (rsv) begin
      cmp_byte(8'(nfall), 8'h00);
    end
  endtask : run_req

  // results, write data feed and a sniffer on the wire itself
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      cmp_byte(rd_data, xrd.size() != 0 ? xrd.pop_front() : 8'hxx);
    end
    if (wr_take === 1'b1 && wq.size() != 0) begin
      void'(wq.pop_front());
    end
    if (wr_stb === 1'b1) begin
      cmp_byte(wr_addr, xwa.size() != 0 ? xwa.pop_front() : 8'hxx);
      cmp_byte(wr_dat, xwd.size() != 0 ? xwd.pop_front() : 8'hxx);
      mem[wr_addr] = wr_dat;
    end
    if (bus.scl && scl_d && sda_d && !bus.sda) begin
      bc = 0;
    end else if (bus.scl && !scl_d && bc < 8) begin
      sb = {sb[6:0], bus.sda};
      bc++;
      if (bc == 8) begin
        cmp_byte(sb, xfirst.size() != 0 ? xfirst.pop_front() : 8'hxx);
      end
    end
    if (!bus.scl && scl_d) begin
      nfall++;
    end
    scl_d = bus.scl;
    sda_d = bus.sda;
  end

  // next write byte must already stand when the master takes it
  always @(negedge clk) begin
    wr_data <= (wq.size() != 0) ? wq[0] : 8'h00;
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (95000) @(posedge clk);
    n_fail++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    auto_inc = 1'b0;
    req_valid = 1'b0;
    req_rnw = 1'b0;
    req_reg = 8'h00;
    req_len = 8'h00;
    scl_d = 1'b1;
    sda_d = 1'b1;
    sb = 8'h00;
    bc = 8;
    n_fail = 0;
    samples_checked = 0;
    void'($urandom(32'h9cee_f249));
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($urandom);
      mdl[i] = mem[i];
    end
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    run_req(1'b0, 8'h02, 8'h03, 1'b1);
    run_req(1'b1, 8'h02, 8'h04, 1'b1);
    run_req(1'b1, 8'h03, 8'h03, 1'b0);
    run_req(1'b0, 8'h1e, 8'h02, 1'b0);
    run_req(1'b0, 8'h20, 8'h01, 1'b1);
    run_req(1'b1, 8'hff, 8'h02, 1'b1);
    run_req(1'b1, 8'($urandom_range(16, 31)), 8'h06, 1'b1);
    close_out();
  end
endmodule : testbench
